// ---- core/dcdc_pkg.sv ----
// Shared constants and types for the dc-dc converter control block.
package dcdc_pkg;
  localparam logic [7:0]  PAGE_MAIN       = 8'h00;
  localparam logic [7:0]  PAGE_MODE       = 8'h0F;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h97;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h96;
  localparam logic [7:0]  ADDR_MODE       = 8'h94;
  localparam logic [7:0]  CONTROL_RESET   = 8'h21;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [2:0]  MODE_RESET      = 3'h0;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
  localparam int          CFG_LOW_POWER_ENABLE_BIT    = 7;
  localparam logic [1:0]  BYPASS_OFF      = 2'h0;
  localparam logic [1:0]  BYPASS_AUTO_OSC = 2'h1;
  localparam logic [11:0] ENTRY_MARGIN_MV = 12'h096;
  localparam logic [11:0] EXIT_MARGIN_MV  = 12'h032;
  localparam logic [11:0] HYST_MV         = 12'h064;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          MINPW1_NS       = 20;
  localparam int          MINPW2_NS       = 40;
  localparam int          MINPW3_NS       = 80;
  localparam int MINPW1_CYC = (MINPW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MINPW2_CYC = (MINPW2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MINPW3_CYC = (MINPW3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SW_PERIOD_CYC   = 10;
  localparam int          ON_BASE_CYC     = 1;
  // Targets in millivolts, code 7 first.
  localparam logic [7:0][11:0] TARGET_MV = {
    12'hCE4, 12'hBB8, 12'hA8C, 12'h960,
    12'h834, 12'h7D0, 12'h76C, 12'h708
  };

  typedef struct packed {
    logic [1:0] min_pw;
    logic       small_sw;
    logic       rsvd;
    logic       adc_sync;
    logic [2:0] output_voltage_select;
  } control_t;

  typedef struct packed {
    logic above_entry;
    logic above_exit;
    logic above_target;
  } cmp_t;

  typedef struct packed {
    logic switching_en;
    logic bypass_sw_on;
    logic bypass_ctrl_en;
    logic bias_en;
    logic low_bias;
    logic low_ilimit;
  } power_t;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'h1,
    ST_HIGH   = 3'h2,
    ST_BYPASS = 3'h4
  } mode_state_t;
endpackage : dcdc_pkg

// ---- core/bit_sync.sv ----
// Two-stage synchroniser for a group of independent level inputs.
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("bit_sync needs at least one bit.");
  end

  // Each bit is synchronised on its own; bits may resolve a cycle apart.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule : bit_sync

// ---- core/dcdc_converter_control.sv ----
// Control, configuration and bypass sequencing of the boost converter.
`timescale 1ns/1ps
module dcdc_converter_control #(
  parameter int SW_PERIOD = dcdc_pkg::SW_PERIOD_CYC,
  parameter int ON_BASE   = dcdc_pkg::ON_BASE_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [7:0]       sfr_page,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  input  wire dcdc_pkg::cmp_t   cmp_raw,
  output dcdc_pkg::power_t      power,
  output logic                  inductor_switch_drive,
  output logic                  small_switch_sel,
  output logic                  adc_sync_en,
  output logic                  adc_track_en,
  output logic                  adc_sar_align,
  output logic      [11:0]      target_mv,
  output logic      [11:0]      entry_mv,
  output logic      [11:0]      exit_mv,
  output logic                  bypass_indicator
);
  import dcdc_pkg::*;

  if (SW_PERIOD < 4 || SW_PERIOD > 255 || ON_BASE < 1 ||
      ON_BASE >= SW_PERIOD || MINPW3_CYC >= SW_PERIOD)
  begin : g_bad_timing
    $error("Switching period too short for the pulse widths.");
  end
  if (ENTRY_MARGIN_MV - EXIT_MARGIN_MV != HYST_MV)
  begin : g_bad_hyst
    $error("Bypass margins disagree with the hysteresis.");
  end

  control_t    ctrl_q;
  logic [7:0]  cfg_q;
  logic [1:0]  byp_sel_q;
  logic        passive_q;
  cmp_t        cmp_s;
  mode_state_t state_q;
  mode_state_t state_d;
  logic [7:0]  cyc_q;
  logic [7:0]  on_cyc;
  logic        byp_en;
  logic        osc_run;
  logic        sel_main;
  logic        sel_mode;

  assign sel_main = (sfr_page == PAGE_MAIN);
  assign sel_mode = (sfr_page == PAGE_MODE);
  assign byp_en   = (byp_sel_q != BYPASS_OFF);
  // Only code 01 keeps the oscillator alive in bypass, for fast exit.
  assign osc_run  = (state_q != ST_BYPASS) ||
                    (byp_sel_q == BYPASS_AUTO_OSC);

  bit_sync #(
    .WIDTH    (3)
  ) u_cmp_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (cmp_raw),
    .sync_out (cmp_s)
  );

  // Register writes; reserved bit 4 is stored as written.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q    <= control_t'(CONTROL_RESET);
      cfg_q     <= CONFIG_RESET;
      byp_sel_q <= MODE_RESET[2:1];
      passive_q <= MODE_RESET[0];
    end
    else if (sfr_wr)
    begin
      if (sel_main && sfr_addr == ADDR_CONTROL)
      begin
        ctrl_q <= control_t'(sfr_wdata);
      end
      else if (sel_main && sfr_addr == ADDR_CONFIG)
      begin
        cfg_q <= sfr_wdata;
      end
      else if (sel_mode && sfr_addr == ADDR_MODE)
      begin
        byp_sel_q <= sfr_wdata[2:1];
        passive_q <= sfr_wdata[0];
      end
    end
  end

  // Register reads, answered one cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sfr_rdata <= UNMAPPED_READ;
    end
    else if (sfr_rd)
    begin
      if (sel_main && sfr_addr == ADDR_CONTROL)
      begin
        sfr_rdata <= ctrl_q;
      end
      else if (sel_main && sfr_addr == ADDR_CONFIG)
      begin
        sfr_rdata <= cfg_q;
      end
      else if (sel_mode && sfr_addr == ADDR_MODE)
      begin
        sfr_rdata <= {4'h0, bypass_indicator, byp_sel_q, passive_q};
      end
      else
      begin
        sfr_rdata <= UNMAPPED_READ;
      end
    end
  end

  // Bypass is left on the exit comparator, not the entry one, which is
  // what gives the two thresholds their hysteresis.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL:
      begin
        if (byp_en && cmp_s.above_entry)
        begin
          state_d = ST_BYPASS;
        end
        else if (cmp_s.above_target)
        begin
          state_d = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (byp_en && cmp_s.above_entry)
        begin
          state_d = ST_BYPASS;
        end
        else if (!cmp_s.above_target)
        begin
          state_d = ST_NORMAL;
        end
      end
      ST_BYPASS:
      begin
        if (!byp_en || !cmp_s.above_exit)
        begin
          state_d = ST_NORMAL;
        end
      end
      default:
      begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_NORMAL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bypass_indicator <= 1'b0;
    end
    else
    begin
      bypass_indicator <= (state_q == ST_BYPASS);
    end
  end

  // Analog power controls.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      power <= '0;
    end
    else
    begin
      power.switching_en   <= (state_q == ST_NORMAL);
      power.bypass_sw_on   <= (state_q == ST_HIGH) && !passive_q;
      power.bypass_ctrl_en <= (state_q != ST_BYPASS) && !passive_q;
      power.bias_en        <= (state_q != ST_BYPASS);
      power.low_bias       <= cfg_q[CFG_LOW_POWER_ENABLE_BIT];
      power.low_ilimit     <= cfg_q[CFG_LOW_POWER_ENABLE_BIT];
    end
  end

  always_comb
  begin
    case (ctrl_q.min_pw)
      2'h1:    on_cyc = 8'(MINPW1_CYC);
      2'h2:    on_cyc = 8'(MINPW2_CYC);
      2'h3:    on_cyc = 8'(MINPW3_CYC);
      default: on_cyc = 8'(ON_BASE);
    endcase
    if (on_cyc < 8'(ON_BASE))
    begin
      on_cyc = 8'(ON_BASE);
    end
  end

  // Switching cycle counter; the rate is a count of system clocks.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_q <= 8'h00;
    end
    else if (!osc_run || cyc_q == 8'(SW_PERIOD - 1))
    begin
      cyc_q <= 8'h00;
    end
    else
    begin
      cyc_q <= cyc_q + 8'h01;
    end
  end

  // The on pulse sits at the start, so the rest is the longest quiet time.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      inductor_switch_drive <= 1'b0;
      adc_track_en          <= 1'b0;
      adc_sar_align         <= 1'b0;
    end
    else
    begin
      inductor_switch_drive <= (state_q == ST_NORMAL) && (cyc_q < on_cyc);
      adc_track_en  <= ctrl_q.adc_sync &&
                       !((state_q == ST_NORMAL) && (cyc_q < on_cyc));
      adc_sar_align <= ctrl_q.adc_sync && osc_run &&
                       (cyc_q == on_cyc);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      small_switch_sel <= CONTROL_RESET[5];
      adc_sync_en      <= CONTROL_RESET[3];
      target_mv        <= TARGET_MV[CONTROL_RESET[2:0]];
      entry_mv         <= TARGET_MV[CONTROL_RESET[2:0]] + ENTRY_MARGIN_MV;
      exit_mv          <= TARGET_MV[CONTROL_RESET[2:0]] + EXIT_MARGIN_MV;
    end
    else
    begin
      small_switch_sel <= ctrl_q.small_sw;
      adc_sync_en      <= ctrl_q.adc_sync;
      target_mv        <= TARGET_MV[ctrl_q.output_voltage_select];
      entry_mv         <= TARGET_MV[ctrl_q.output_voltage_select] + ENTRY_MARGIN_MV;
      exit_mv          <= TARGET_MV[ctrl_q.output_voltage_select] + EXIT_MARGIN_MV;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  bypass_entry_a: assert property (
    state_q != ST_BYPASS && byp_en && cmp_s.above_entry
    |=> state_q == ST_BYPASS ##1 bypass_indicator)
    else $error("Bypass not entered above the entry threshold.");

  bypass_exit_a: assert property (
    state_q == ST_BYPASS && !cmp_s.above_exit
    |=> state_q == ST_NORMAL ##1 power.switching_en)
    else $error("Bypass not left below the exit threshold.");

  hysteresis_hold_a: assert property (
    state_q == ST_BYPASS && byp_en && cmp_s.above_exit
    |=> state_q == ST_BYPASS)
    else $error("Bypass left while still above the exit threshold.");

  bypass_power_a: assert property (
    state_q == ST_BYPASS
    |=> !power.bias_en && !power.bypass_sw_on && !power.switching_en)
    else $error("Bias or bypass switch active during bypass.");

  high_idle_a: assert property (
    state_q == ST_HIGH && !passive_q
    |=> power.bypass_sw_on && power.bias_en && !inductor_switch_drive)
    else $error("Converter still switching above the target.");

  bypass_off_a: assert property (
    byp_sel_q == BYPASS_OFF |=> state_q != ST_BYPASS)
    else $error("Bypass taken while bypass is disabled.");

  passive_diode_a: assert property (
    passive_q |=> !power.bypass_ctrl_en && !power.bypass_sw_on)
    else $error("Bypass switch control active in passive diode mode.");

  low_power_a: assert property (
    cfg_q[CFG_LOW_POWER_ENABLE_BIT] |=> power.low_bias && power.low_ilimit)
    else $error("Low power mode not applied.");

  control_write_a: assert property (
    sfr_wr && sfr_page == PAGE_MAIN && sfr_addr == ADDR_CONTROL
    |=> ctrl_q == $past(sfr_wdata) ##1 target_mv == TARGET_MV[ctrl_q.output_voltage_select])
    else $error("Control write did not take effect.");

  pulse_width_a: assert property (
    $rose(inductor_switch_drive) && ctrl_q.min_pw == 2'h3 &&
    $stable(ctrl_q) && state_q == ST_NORMAL && cyc_q == 8'h01
    |-> inductor_switch_drive [*2])
    else $error("Switch pulse shorter than the minimum width.");
endmodule : dcdc_converter_control

// ---- bench/dcdc_converter_control_test.sv ----
// Self-checking bench for the dc-dc converter control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("[FAIL] %s exp %h got %h", nm, ex, got); \
    end \
  end

module dcdc_converter_control_test;
  import dcdc_pkg::*;
  localparam int SWP = 10;
  localparam int ONB = 1;
  logic        ref_clk = 1'b0;
  logic        rstn;
  logic [7:0]  sfr_page;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  cmp_t        cmp_raw;
  power_t      power;
  logic        inductor_switch_drive;
  logic        small_switch_sel;
  logic        adc_sync_en;
  logic        adc_track_en;
  logic        adc_sar_align;
  logic [11:0] target_mv;
  logic [11:0] entry_mv;
  logic [11:0] exit_mv;
  logic        bypass_indicator;
  int          fails;
  int          n_checks;
  int          nd;
  int          nt;
  int          na;
  int          exp_on;
  int          pw_ns [4] = '{0, 20, 40, 80};
  logic [11:0] tgt [8] = '{12'h708, 12'h76C, 12'h7D0, 12'h834,
                           12'h960, 12'hA8C, 12'hBB8, 12'hCE4};

  always #20 ref_clk = ~ref_clk;

  dcdc_converter_control #(.SW_PERIOD(SWP), .ON_BASE(ONB)) u_dut (
    .ref_clk, .rstn, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .cmp_raw, .power, .inductor_switch_drive, .small_switch_sel,
    .adc_sync_en, .adc_track_en, .adc_sar_align, .target_mv, .entry_mv,
    .exit_mv, .bypass_indicator
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : edges

  // One strobed access; the strobe is held over exactly one taking edge.
  task automatic acc(input logic [7:0] pg, ad, dt, input logic w);
    @(posedge ref_clk);
    #1;
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = dt;
    sfr_wr = w;
    sfr_rd = ~w;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask : acc

  task automatic rd_chk(input string nm, input logic [7:0] pg, ad, ex);
    acc(pg, ad, 8'h00, 1'b0);
    `CHK(nm, ex, sfr_rdata)
  endtask : rd_chk

  // Counts drive, track and align cycles over two switch periods.
  task automatic count_cycle();
    nd = 0;
    nt = 0;
    na = 0;
    repeat (2 * SWP)
    begin
      @(posedge ref_clk);
      #1;
      nd += (inductor_switch_drive === 1'b1);
      nt += (adc_track_en === 1'b1);
      na += (adc_sar_align === 1'b1);
    end
  endtask : count_cycle

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    rstn = 1'b0;
    sfr_page = 8'h00;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    cmp_raw = '0;
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    edges(1);
    rd_chk("control", 8'h00, 8'h97, 8'h21);
    rd_chk("config", 8'h00, 8'h96, 8'h00);
    rd_chk("mode", 8'h0F, 8'h94, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h95, 8'h00);
    `CHK("target", 12'h76C, target_mv)
    `CHK("small", 1'b1, small_switch_sel)
    `CHK("switching", 1'b1, power.switching_en)
    // A control write on the wrong page must not land.
    acc(8'h0F, 8'h97, 8'h45, 1'b1);
    rd_chk("wrong page", 8'h00, 8'h97, 8'h21);
    // Reserved bit 4 is always written as zero here.
    for (int i = 0; i < 8; i++)
    begin
      acc(8'h00, 8'h97, {5'h04, i[2:0]}, 1'b1);
      edges(1);
      `CHK("target", tgt[i], target_mv)
      `CHK("entry", tgt[i] + 12'h096, entry_mv)
      `CHK("exit", tgt[i] + 12'h032, exit_mv)
      `CHK("hyst", 12'h064, entry_mv - exit_mv)
      rd_chk("readback", 8'h00, 8'h97, {5'h04, i[2:0]});
    end
    // The ADC divider sits outside this block and is taken as already zero.
    for (int m = 0; m < 4; m++)
    begin
      acc(8'h00, 8'h97, {m[1:0], 6'h0D}, 1'b1);
      edges(SWP);
      count_cycle();
      exp_on = (pw_ns[m] + 39) / 40;
      if (exp_on < ONB)
        exp_on = ONB;
      `CHK("on cycles", 2 * exp_on, nd)
      `CHK("align", 2, na)
      `CHK("track", 2 * (SWP - exp_on), nt)
      `CHK("sync", 1'b1, adc_sync_en)
      `CHK("small", 1'b0, small_switch_sel)
    end
    acc(8'h00, 8'h96, 8'h80, 1'b1);
    edges(1);
    `CHK("low bias", 1'b1, power.low_bias)
    `CHK("low limit", 1'b1, power.low_ilimit)
    cmp_raw = 3'h7;
    edges(6);
    `CHK("no bypass", 1'b0, bypass_indicator)
    `CHK("stop sw", 1'b0, power.switching_en)
    `CHK("bypass sw", 1'b1, power.bypass_sw_on)
    `CHK("bias", 1'b1, power.bias_en)
    acc(8'h0F, 8'h94, 8'h02, 1'b1);
    edges(4);
    `CHK("indicator", 1'b1, bypass_indicator)
    `CHK("bias", 1'b0, power.bias_en)
    `CHK("bypass sw", 1'b0, power.bypass_sw_on)
    `CHK("stop sw", 1'b0, power.switching_en)
    rd_chk("mode", 8'h0F, 8'h94, 8'h0A);
    cmp_raw = 3'h3;
    edges(6);
    `CHK("hold", 1'b1, bypass_indicator)
    cmp_raw = 3'h0;
    edges(6);
    `CHK("leave", 1'b0, bypass_indicator)
    `CHK("switching", 1'b1, power.switching_en)
    `CHK("bias", 1'b1, power.bias_en)
    cmp_raw = 3'h7;
    edges(6);
    acc(8'h0F, 8'h94, 8'h00, 1'b1);
    edges(3);
    `CHK("forced out", 1'b0, bypass_indicator)
    // Above the target the bypass switch would be on without the diode mode.
    cmp_raw = 3'h1;
    acc(8'h0F, 8'h94, 8'hF9, 1'b1);
    edges(5);
    `CHK("bypass sw", 1'b0, power.bypass_sw_on)
    `CHK("bypass ctl", 1'b0, power.bypass_ctrl_en)
    rd_chk("mode ro", 8'h0F, 8'h94, 8'h01);
    // A second reset in mid-run must bring every register back.
    rstn = 1'b0;
    edges(2);
    rstn = 1'b1;
    edges(1);
    rd_chk("mode reset", 8'h0F, 8'h94, 8'h00);
    rd_chk("control reset", 8'h00, 8'h97, 8'h21);
    rd_chk("config reset", 8'h00, 8'h96, 8'h00);
    report_and_stop();
  end
endmodule : dcdc_converter_control_test
